// ===== pkg/sms_pkg.sv
// Package: constants, modes and timing of the system mode sequencer
package sms_pkg;
  // Operating modes, binary codes
  typedef enum logic [2:0] {
    SMS_INIT     = 3'h0,
    SMS_NORMAL   = 3'h1,
    SMS_STOP     = 3'h2,
    SMS_SLEEP    = 3'h3,
    SMS_RESTART  = 3'h4,
    SMS_FAILSAFE = 3'h5
  } sms_mode_e;
  // Mode-select field codes written by the host
  localparam logic [1:0] SMS_SEL_NORMAL = 2'h0;
  localparam logic [1:0] SMS_SEL_STOP = 2'h1;
  localparam logic [1:0] SMS_SEL_SLEEP = 2'h2;
  localparam logic [1:0] SMS_SEL_RESET = 2'h3;
  // Clock rate and times
  localparam int SMS_CLK_HZ = 40000000;
  localparam int SMS_RESET_DELAY_US = 10;
  localparam int SMS_LONG_WINDOW_MS = 200;
  localparam int SMS_RD_CYCLES = SMS_RESET_DELAY_US * (SMS_CLK_HZ / 1000000);
  localparam int SMS_LW_CYCLES = SMS_LONG_WINDOW_MS * (SMS_CLK_HZ / 1000);
  // Reset values and counts
  localparam logic SMS_RST_COUNT_SEL_RESET = 1'b1;
  localparam logic SMS_RST_LIMIT_RESET = 1'b0;
  localparam logic [1:0] SMS_MAX_RESETS = 2'h3;
  localparam int SMS_CNT_W = 24;
endpackage

// ===== pkg/sms_tmr_if.sv
// Interface: timer start and expiry between sequencer and timer
`timescale 1ns/1ps
interface sms_tmr_if;
  logic start;
  logic [23:0] load;
  logic run;
  logic expired;
  modport ctrl (output start, output load, output run, input expired);
  modport tmr (input start, input load, input run, output expired);
endinterface

// ===== logic/sms_timer.sv
// Down counter used for reset delay and watchdog windows
`timescale 1ns/1ps
module sms_timer (
  input wire logic i_clock,    // System clock
  input wire logic i_rst_n,    // Synchronous reset, active low
  sms_tmr_if.tmr t             // Control from the sequencer
);
  import sms_pkg::*;
  logic [23:0] cnt_reg;
  logic exp_reg;
  // Load on start, count while run, flag once at zero
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cnt_reg <= 24'h0;
      exp_reg <= 1'b0;
    end else if (t.start) begin
      cnt_reg <= t.load;
      exp_reg <= 1'b0;
    end else if (t.run && cnt_reg != 24'h0) begin
      cnt_reg <= cnt_reg - 24'h1;
      exp_reg <= (cnt_reg == 24'h1);
    end else begin
      exp_reg <= 1'b0;
    end
  end
  assign t.expired = exp_reg;
endmodule

// ===== logic/sms_sequencer.sv
// Operating mode sequencer with start-up configuration and watchdog
// Operation
// RULE1: Six modes exist; exactly one is active.
// RULE2: Init is entered at power-up and after software reset.
// RULE3: Restart after wake or failure; leaves to normal after reset delay.
// RULE4: Critical failure enters fail-safe, regulator off, until wake and cool. Code ignores it in init and sleep.
// RULE5: Stop keeps main regulator on; sleep turns it off.
// RULE6: Development mode stops the watchdog; chosen by low test pin.
// RULE7: Control arrives over a 16-bit SPI; host controls, device targets.
// RULE8: Mode field sets mode; restart clears it so reads show current mode.
// RULE9: In init the test pin is an input with pull-up and sampled.
// RULE10: Test low gives config 0, no watchdog reset; host sends a command.
// RULE11: Config 1: first missed trigger gives fail outputs and restart.
// RULE12: Config 3: second missed trigger gives fail outputs and restart.
// RULE13: Host picks config 1 or 3 with the restart count select bit.
// RULE14: Supply crossing threshold in init starts one reset delay period.
// RULE15: After that period reset releases and long open window starts.
// RULE16: Any SPI command in init moves to normal, illegal ones too.
// RULE17: Long window expiry records failure, restarts, gives one reset.
// RULE18: With limit bit set, no resets after three consecutive failures.
// RULE19: Wake events in init are dropped unrecorded.
// RULE20: Host should first service and configure the watchdog.
// RULE21: No undervoltage flag or fail outputs while supplies still rising.
// RULE22: Reset held low below threshold, released one delay later.
// RULE23: Stop to sleep request is refused, flags SPI failure, restarts.
// RULE24: Sleep with wake flags pending wakes at once via restart.
// RULE25: Reset output goes low as soon as sleep is commanded.
// RULE26: Test configuration is latched at period end until next init.
`timescale 1ns/1ps
module sms_sequencer #(
  parameter int RD_CYCLES = sms_pkg::SMS_RD_CYCLES, // Reset delay
  parameter int LW_CYCLES = sms_pkg::SMS_LW_CYCLES  // Long open window
) (
  input wire logic i_clock,               // 40 MHz clock
  input wire logic i_rst_n,               // Sync reset, power-on, active low
  input wire logic i_spi_frame,           // Any 16-bit frame received, pulse
  input wire logic i_spi_mode_wr,         // Mode field write, pulse
  input wire logic [1:0] i_spi_mode_sel,  // Written mode field value
  input wire logic i_spi_wd_trig,         // Watchdog trigger, pulse
  input wire logic i_spi_hw_wr,           // Hardware control write, pulse
  input wire logic i_restart_count_select, // Restart count select value
  input wire logic i_spi_wd_wr,           // Watchdog control write, pulse
  input wire logic i_reset_limit,         // Reset limit bit value
  input wire logic i_supply_ok,           // Main supply above threshold, pin
  input wire logic i_vs_ok,               // Supply input above UV timeout, pin
  input wire logic i_critical_fail,       // Thermal level two or short, pin
  input wire logic i_overtemp,            // Overtemperature present, pin
  input wire logic i_wake,                // Wake on CAN, LIN or wake input
  input wire logic i_wake_flags_pend,     // Wake source flags still set
  input wire logic i_test_pin,            // Test pin level, pin
  output logic [2:0] o_operating_mode_field, // Mode currently in force
  output logic o_reset_output_n,          // Reset output, active low
  output logic o_main_reg_en,             // Main regulator enable
  output logic o_fail_safe_outputs,       // Fail-safe outputs active
  output logic o_test_pullup_en,          // Test pin pull-up enabled
  output logic o_dev_mode,                // Development mode latched
  output logic o_restart_count_state,     // Restart count state bit
  output logic o_wd_fail,                 // Watchdog failure recorded
  output logic o_spi_fail,                // SPI failure flag
  output logic o_main_supply_undervoltage_flag, // Supply UV recorded
  output logic o_wake_recorded            // Wake event recorded
);
  import sms_pkg::*;

  sms_tmr_if tif ();
  sms_timer u_timer (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .t(tif.tmr)
  );

  // Pin synchronisers
  logic [5:0] s1_reg, s2_reg;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s1_reg <= 6'h0;
      s2_reg <= 6'h0;
    end else begin
      s1_reg <= {i_supply_ok, i_vs_ok, i_critical_fail, i_overtemp,
                 i_wake, i_test_pin};
      s2_reg <= s1_reg;
    end
  end
  logic supply_ok, vs_ok, crit, otemp, wake, test_lvl;
  assign {supply_ok, vs_ok, crit, otemp, wake, test_lvl} = s2_reg;

  sms_mode_e mode_reg, mode_next;
  logic mon_reg;        // Monitoring period running in init
  logic window_reg;     // Long open window running
  logic dev_reg, cfg_sel_reg, limit_reg, miss_reg, fo_reg;
  logic [1:0] rstcnt_reg;
  logic sleep_req, stop_to_sleep, wd_expire, wd_reset;

  // Requests decoded from the mode field write, and long window expiry
  assign sleep_req = i_spi_mode_wr && i_spi_mode_sel == SMS_SEL_SLEEP;
  assign stop_to_sleep = sleep_req && mode_reg == SMS_STOP; // RULE23
  assign wd_expire = window_reg && tif.expired && !dev_reg; // RULE6 RULE17
  // Config 3 needs a prior miss; limit stops further resets
  assign wd_reset = wd_expire && (cfg_sel_reg || miss_reg) // RULE11 RULE12
    && !(limit_reg && rstcnt_reg == SMS_MAX_RESETS); // RULE18

  // Mode transitions, one mode at a time
  always_comb begin
    mode_next = mode_reg; // RULE1
    case (mode_reg)
      SMS_INIT: begin
        if (i_spi_frame && !mon_reg && o_reset_output_n)
          mode_next = SMS_NORMAL; // RULE16 RULE10
        else if (wd_reset)
          mode_next = SMS_RESTART;
      end
      SMS_NORMAL, SMS_STOP: begin
        if (crit) mode_next = SMS_FAILSAFE; // RULE4
        else if (!supply_ok || wd_reset || stop_to_sleep)
          mode_next = SMS_RESTART; // RULE3 RULE23
        else if (i_spi_mode_wr) begin
          case (i_spi_mode_sel)
            SMS_SEL_NORMAL: mode_next = SMS_NORMAL;
            SMS_SEL_STOP: mode_next = SMS_STOP;
            SMS_SEL_SLEEP: mode_next = i_wake_flags_pend ?
              SMS_RESTART : SMS_SLEEP; // RULE24
            SMS_SEL_RESET: mode_next = SMS_INIT; // RULE2
            default: mode_next = mode_reg;
          endcase
        end
      end
      SMS_SLEEP: begin
        if (wake) mode_next = SMS_RESTART; // RULE3
      end
      SMS_RESTART: begin
        if (crit) mode_next = SMS_FAILSAFE;
        else if (supply_ok && tif.expired)
          mode_next = SMS_NORMAL; // RULE3
      end
      SMS_FAILSAFE: begin
        if (wake && !otemp && !crit) mode_next = SMS_RESTART; // RULE4
      end
      default: mode_next = SMS_INIT;
    endcase
  end

  // Mode register; restart entry clears the field via mode itself
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) mode_reg <= SMS_INIT; // RULE2
    else mode_reg <= mode_next; // RULE8
  end

  // Monitoring period and watchdog window sequencing
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || (mode_next == SMS_INIT && mode_reg != SMS_INIT)) begin
      mon_reg <= 1'b0;
      window_reg <= 1'b0;
    end else if (mode_reg == SMS_INIT && !mon_reg && !window_reg
                 && !o_reset_output_n && supply_ok) begin
      mon_reg <= 1'b1; // RULE14
    end else if (mon_reg && tif.expired) begin
      mon_reg <= 1'b0;
      window_reg <= 1'b1; // RULE15
    end else if (wd_expire || i_spi_wd_trig || mode_next == SMS_SLEEP
                 || mode_next == SMS_RESTART) begin
      window_reg <= 1'b0;
    end
  end

  // Timer control: reset delay or long window loads
  always_comb begin
    tif.start = 1'b0;
    tif.load = 24'(RD_CYCLES);
    if (mode_reg == SMS_INIT && !mon_reg && !window_reg
        && !o_reset_output_n && supply_ok) begin
      tif.start = 1'b1;
    end else if (mon_reg && tif.expired) begin
      tif.start = 1'b1;
      tif.load = 24'(LW_CYCLES);
    end else if (mode_next == SMS_RESTART && mode_reg != SMS_RESTART) begin
      tif.start = 1'b1;
    end else if (mode_reg == SMS_RESTART && !supply_ok) begin
      tif.start = 1'b1; // Delay restarts until supply is good
    end
  end
  assign tif.run = !dev_reg || !window_reg; // RULE6

  // Configuration latch from the test pin, held until next init
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) dev_reg <= 1'b0;
    else if (mon_reg && tif.expired) dev_reg <= !test_lvl; // RULE9 RULE26
  end

  // Host-written restart count select and reset limit
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || mode_reg == SMS_INIT && mode_next == SMS_INIT
        && !window_reg && !mon_reg) begin
      cfg_sel_reg <= SMS_RST_COUNT_SEL_RESET;
      limit_reg <= SMS_RST_LIMIT_RESET;
    end else begin
      if (i_spi_hw_wr) cfg_sel_reg <= i_restart_count_select; // RULE13
      if (i_spi_wd_wr) limit_reg <= i_reset_limit;
    end
  end

  // Miss memory for config 3 and consecutive reset count
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      miss_reg <= 1'b0;
      rstcnt_reg <= 2'h0;
    end else if (i_spi_wd_trig) begin
      miss_reg <= 1'b0;
      rstcnt_reg <= 2'h0; // Good service breaks the sequence
    end else if (wd_expire) begin
      miss_reg <= !miss_reg && !cfg_sel_reg; // RULE12
      if (wd_reset) rstcnt_reg <= rstcnt_reg + 2'h1; // RULE18
    end
  end

  // Reset output: low at sleep command, below threshold, in restart
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) o_reset_output_n <= 1'b0;
    else if (!supply_ok || sleep_req || mode_next == SMS_RESTART
             || mode_next == SMS_SLEEP || mode_next == SMS_FAILSAFE
             || (mode_next == SMS_INIT && mode_reg != SMS_INIT))
      o_reset_output_n <= 1'b0; // RULE22 RULE25
    else if ((mon_reg || mode_reg == SMS_RESTART) && tif.expired)
      o_reset_output_n <= 1'b1; // RULE15 RULE22
  end

  // Fail-safe outputs and main regulator
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      fo_reg <= 1'b0;
      o_main_reg_en <= 1'b1;
    end else begin
      if (wd_reset) fo_reg <= 1'b1; // RULE11 RULE12
      else if (mode_next == SMS_FAILSAFE) fo_reg <= 1'b1;
      else if (mode_next == SMS_INIT && mode_reg != SMS_INIT)
        fo_reg <= 1'b0;
      o_main_reg_en <= !(mode_next == SMS_SLEEP
                         || mode_next == SMS_FAILSAFE); // RULE4 RULE5
    end
  end

  // Status flags; sticky, cleared only by the synchronous reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_wd_fail <= 1'b0;
      o_spi_fail <= 1'b0;
      o_main_supply_undervoltage_flag <= 1'b0;
      o_wake_recorded <= 1'b0;
    end else begin
      if (wd_expire) o_wd_fail <= 1'b1; // RULE17
      if (stop_to_sleep) o_spi_fail <= 1'b1; // RULE23
      // Suppressed during the power-up ramp
      if (!supply_ok && (supply_ok || vs_ok || mode_reg != SMS_INIT))
        o_main_supply_undervoltage_flag <= 1'b1; // RULE21
      if (wake && mode_reg != SMS_INIT)
        o_wake_recorded <= 1'b1; // RULE19
    end
  end

  // Registered outputs
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_operating_mode_field <= 3'h0;
      o_fail_safe_outputs <= 1'b0;
      o_test_pullup_en <= 1'b1;
      o_dev_mode <= 1'b0;
      o_restart_count_state <= SMS_RST_COUNT_SEL_RESET;
    end else begin
      o_operating_mode_field <= mode_next; // RULE8
      o_fail_safe_outputs <= fo_reg && (supply_ok || vs_ok); // RULE21
      o_test_pullup_en <= (mode_next == SMS_INIT); // RULE9
      o_dev_mode <= dev_reg; // RULE10
      o_restart_count_state <= cfg_sel_reg;
    end
  end
endmodule

// ===== tb/sms_props.sv
// Checker: concurrent properties on the mode sequencer ports
`timescale 1ns/1ps
module sms_props
  import sms_pkg::*;
(
  input wire logic i_clock,                // System clock
  input wire logic i_rst_n,                // Sync reset, active low
  input wire logic i_spi_frame,            // Any frame pulse
  input wire logic i_spi_mode_wr,          // Mode write pulse
  input wire logic [1:0] i_spi_mode_sel,   // Mode field value
  input wire logic [2:0] o_operating_mode_field, // Mode in force
  input wire logic o_reset_output_n,       // Reset output
  input wire logic o_main_reg_en,          // Regulator enable
  input wire logic o_test_pullup_en,       // Test pin pull-up
  input wire logic o_spi_fail              // SPI failure flag
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Mode code and a sleep request seen in a given mode
  logic sleep_req;
  assign sleep_req = i_spi_mode_wr && i_spi_mode_sel == SMS_SEL_SLEEP;
  a_mode_code_legal:
    assert property (o_operating_mode_field <= 3'h5)
    else $error("mode code out of range");
  a_stop_reg_on:
    assert property (o_operating_mode_field == SMS_STOP |-> o_main_reg_en)
    else $error("regulator off in stop");
  a_sleep_reg_off:
    assert property (o_operating_mode_field == SMS_SLEEP |-> !o_main_reg_en)
    else $error("regulator on in sleep");
  a_failsafe_reg_off:
    assert property (o_operating_mode_field == SMS_FAILSAFE |-> !o_main_reg_en)
    else $error("regulator on in fail-safe");
  a_init_pullup_on:
    assert property (o_operating_mode_field == SMS_INIT |-> o_test_pullup_en)
    else $error("pull-up off in init");
  a_init_frame_normal:
    assert property (o_operating_mode_field == SMS_INIT && o_reset_output_n
      && i_spi_frame && !i_spi_mode_wr |-> ##[1:2]
      o_operating_mode_field == SMS_NORMAL)
    else $error("frame in init did not reach normal");
  a_sleep_reset_low:
    assert property (o_operating_mode_field == SMS_NORMAL && sleep_req
      |-> ##[1:2] !o_reset_output_n)
    else $error("reset not low after sleep command");
  a_stop_sleep_refused:
    assert property (o_operating_mode_field == SMS_STOP && sleep_req
      |-> ##[1:2] (o_operating_mode_field == SMS_RESTART && o_spi_fail))
    else $error("stop to sleep not refused");
  a_restart_reset_low:
    assert property (o_operating_mode_field == SMS_RESTART
      |-> !o_reset_output_n)
    else $error("reset released in restart");
  c_stop_seen: cover property (o_operating_mode_field == SMS_STOP);
  c_sleep_seen: cover property (o_operating_mode_field == SMS_SLEEP);
  c_fs_seen: cover property (o_operating_mode_field == SMS_FAILSAFE);
endmodule

// ===== tb/sms_host.sv
// Host model: issues SPI frames and mode writes as pulses
`timescale 1ns/1ps
module sms_host (
  input wire logic i_clock,        // System clock
  output logic o_spi_frame,        // Frame pulse
  output logic o_mode_wr,          // Mode write pulse
  output logic [1:0] o_mode_sel,   // Mode field value
  output logic o_wd_trig           // Watchdog service pulse
);
  initial begin
    o_spi_frame = 1'b0;
    o_mode_wr = 1'b0;
    o_mode_sel = 2'h0;
    o_wd_trig = 1'b0;
  end
  // One 16-bit frame: every command also counts as a frame
  task automatic send(input logic w, input logic [1:0] s, input logic t);
    @(posedge i_clock);
    #2;
    o_spi_frame = 1'b1;
    o_mode_wr = w;
    o_mode_sel = s;
    o_wd_trig = t;
    @(posedge i_clock);
    #2;
    o_spi_frame = 1'b0;
    o_mode_wr = 1'b0;
    o_wd_trig = 1'b0;
  endtask
endmodule

// ===== tb/testbench.sv
// Testbench: mode sequencing, start-up and watchdog scenarios
`timescale 1ns/1ps
module testbench;
  import sms_pkg::*;
  localparam int RD = 20;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_supply_ok = 1'b0;
  logic i_critical_fail = 1'b0, i_overtemp = 1'b0, i_wake = 1'b0;
  logic i_test_pin = 1'b1, i_vs_ok = 1'b1, wfp = 1'b0;
  logic spi_frame, mode_wr, wd_trig;
  logic [1:0] mode_sel;
  logic [2:0] mode;
  logic rst_n_out, reg_en, fso, dev, wdf, spf;
  int num_errors = 0, n_checks = 0, n;
  always #12.5 i_clock = ~i_clock;
  sms_host host (.i_clock(i_clock), .o_spi_frame(spi_frame),
    .o_mode_wr(mode_wr), .o_mode_sel(mode_sel), .o_wd_trig(wd_trig));
  // Hardware and watchdog control writes are left at their reset values
  sms_sequencer #(.RD_CYCLES(RD), .LW_CYCLES(200)) dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_spi_frame(spi_frame),
    .i_spi_mode_wr(mode_wr), .i_spi_mode_sel(mode_sel),
    .i_spi_wd_trig(wd_trig), .i_spi_hw_wr(1'b0),
    .i_restart_count_select(1'b1), .i_spi_wd_wr(1'b0),
    .i_reset_limit(1'b0), .i_supply_ok(i_supply_ok), .i_vs_ok(i_vs_ok),
    .i_critical_fail(i_critical_fail), .i_overtemp(i_overtemp),
    .i_wake(i_wake), .i_wake_flags_pend(wfp), .i_test_pin(i_test_pin),
    .o_operating_mode_field(mode), .o_reset_output_n(rst_n_out),
    .o_main_reg_en(reg_en), .o_fail_safe_outputs(fso),
    .o_test_pullup_en(), .o_dev_mode(dev), .o_restart_count_state(),
    .o_wd_fail(wdf), .o_spi_fail(spf),
    .o_main_supply_undervoltage_flag(), .o_wake_recorded());
  task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clock);
    #2;
  endtask
  // Bounded wait for a mode; running out ends the run as a mismatch
  task automatic wmode(input logic [2:0] m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      cyc(1);
      n++;
    end
    if (mode !== m) begin
      num_errors++;
      $display("[FAIL] wait mode expected %0h seen %0h", m, mode);
      report_and_stop();
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    cyc(12);
    i_rst_n = 1'b1;
    // Start-up: reset held while supply low, released a delay later
    cyc(40);
    chk("ro_low", 3'h0, {2'h0, rst_n_out});
    i_supply_ok = 1'b1;
    n = 0;
    while (rst_n_out !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("delay_ok", 3'h1, {2'h0, (n >= RD && n < RD + 10)});
    chk("init_mode", SMS_INIT, mode);
    i_test_pin = 1'b0;
    host.send(1'b0, 2'h0, 1'b0);
    cyc(2);
    chk("frame_normal", SMS_NORMAL, mode);
    chk("cfg_latched", 3'h0, {2'h0, dev});
    $display("test startup done");
    // Missed trigger in configuration 1 restarts at once
    wmode(SMS_RESTART, 300);
    chk("wd_fail", 3'h1, {2'h0, wdf});
    // Fail outputs trail the restart entry by one register stage
    cyc(1);
    chk("fail_out", 3'h1, {2'h0, fso});
    wmode(SMS_NORMAL, 60);
    $display("test watchdog done");
    // Stop keeps regulator, stop to sleep is refused
    host.send(1'b1, SMS_SEL_STOP, 1'b1);
    cyc(2);
    chk("stop", SMS_STOP, mode);
    chk("stop_reg", 3'h1, {2'h0, reg_en});
    host.send(1'b1, SMS_SEL_SLEEP, 1'b1);
    cyc(2);
    chk("refused", SMS_RESTART, mode);
    chk("spi_fail", 3'h1, {2'h0, spf});
    wmode(SMS_NORMAL, 60);
    $display("test stop done");
    // Sleep drops reset and regulator, wake returns via restart
    host.send(1'b1, SMS_SEL_SLEEP, 1'b1);
    cyc(1);
    chk("sleep_ro", 3'h0, {2'h0, rst_n_out});
    cyc(1);
    chk("sleep", SMS_SLEEP, mode);
    chk("sleep_reg", 3'h0, {2'h0, reg_en});
    i_wake = 1'b1;
    wmode(SMS_RESTART, 10);
    i_wake = 1'b0;
    wmode(SMS_NORMAL, 60);
    $display("test sleep done");
    // Critical failure: fail-safe until wake with temperature cleared
    i_critical_fail = 1'b1;
    i_overtemp = 1'b1;
    wmode(SMS_FAILSAFE, 10);
    chk("fs_reg", 3'h0, {2'h0, reg_en});
    i_critical_fail = 1'b0;
    i_wake = 1'b1;
    cyc(10);
    chk("fs_hot", SMS_FAILSAFE, mode);
    i_overtemp = 1'b0;
    wmode(SMS_RESTART, 10);
    i_wake = 1'b0;
    wmode(SMS_NORMAL, 60);
    $display("test failsafe done");
    // Sleep with wake flags still set goes straight to restart
    wfp = 1'b1;
    host.send(1'b1, SMS_SEL_SLEEP, 1'b0);
    chk("sleep_pend", SMS_RESTART, mode);
    wfp = 1'b0;
    wmode(SMS_NORMAL, 60);
    $display("test pending wake done");
    // Soft reset with test pin low selects development mode
    host.send(1'b1, SMS_SEL_RESET, 1'b0);
    cyc(2);
    chk("soft_init", SMS_INIT, mode);
    n = 0;
    while (rst_n_out !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    // Development flag output lags the latch by one cycle
    cyc(1);
    chk("dev_mode", 3'h1, {2'h0, dev});
    host.send(1'b0, 2'h0, 1'b0);
    cyc(400);
    chk("dev_no_wd", SMS_NORMAL, mode);
    $display("test devmode done");
    report_and_stop();
  end
endmodule
bind sms_sequencer sms_props u_props (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_spi_frame(i_spi_frame), .i_spi_mode_wr(i_spi_mode_wr),
  .i_spi_mode_sel(i_spi_mode_sel),
  .o_operating_mode_field(o_operating_mode_field),
  .o_reset_output_n(o_reset_output_n), .o_main_reg_en(o_main_reg_en),
  .o_test_pullup_en(o_test_pullup_en), .o_spi_fail(o_spi_fail));
